// *** logic/odt_params.svh ***
/*
  Register offsets, field positions, reset values and timing counts
  of the orientation detect status block.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef ODT_PARAMS_SVH
`define ODT_PARAMS_SVH

// register offsets on the internal register port
`define ODT_ADDR_STATUS 8'h10
`define ODT_ADDR_CONFIG 8'h11
`define ODT_ADDR_DBCOUNT 8'h12
`define ODT_ADDR_BFZCOMP 8'h13
`define ODT_ADDR_TRIP 8'h14

// status register field positions
`define ODT_ST_FLAG_BIT 7
`define ODT_ST_LOCK_BIT 6
`define ODT_ST_PL_HI 2
`define ODT_ST_PL_LO 1
`define ODT_ST_BF_BIT 0

// config register field positions
`define ODT_CFG_DBMODE_BIT 7
`define ODT_CFG_EN_BIT 6

// reset values
`define ODT_RST_DBMODE 1'b1
`define ODT_RST_EN 1'b0
`define ODT_RST_DBCOUNT 8'h00
`define ODT_RST_PL_CODE 2'h0
`define ODT_RST_LOCK 1'b0
`define ODT_RST_BF 1'b0

// fixed read-only patterns
`define ODT_BFZCOMP_VALUE 8'h44
`define ODT_TRIP_VALUE 8'h84

// timing: smallest debounce time step and clock period
`define ODT_STEP_BASE_NS 1250000
`define ODT_CLK_PERIOD_NS 50

// time step multipliers of the base step (1.25 ms units)
`define ODT_MULT_1 8'h01
`define ODT_MULT_2 8'h02
`define ODT_MULT_4 8'h04
`define ODT_MULT_8 8'h08
`define ODT_MULT_16 8'h10
`define ODT_MULT_64 8'h40
`define ODT_MULT_128 8'h80

`endif

// *** logic/odt_pkg.sv ***
/*
  Types shared by the orientation detect status block.
  Assumes odt_params.svh is on the include path.
*/
`include "odt_params.svh"

package odt_pkg;

  // portrait/landscape code, ascending as reported in the status register
  typedef enum logic [1:0] {
    ODT_PORTRAIT_UP = 2'h0,
    ODT_PORTRAIT_DOWN = 2'h1,
    ODT_LANDSCAPE_RIGHT = 2'h2,
    ODT_LANDSCAPE_LEFT = 2'h3
  } odt_pl_code_t;

  // output sample rate selection, fastest first
  typedef enum logic [2:0] {
    ODT_ODR_800 = 3'h0,
    ODT_ODR_400 = 3'h1,
    ODT_ODR_200 = 3'h2,
    ODT_ODR_100 = 3'h3,
    ODT_ODR_50 = 3'h4,
    ODT_ODR_12P5 = 3'h5,
    ODT_ODR_6P25 = 3'h6,
    ODT_ODR_1P56 = 3'h7
  } odt_odr_t;

  // oversampling mode
  typedef enum logic [1:0] {
    ODT_OS_NORMAL = 2'h0,
    ODT_OS_LPLN = 2'h1,
    ODT_OS_HIGHRES = 2'h2,
    ODT_OS_LOWPOWER = 2'h3
  } odt_osmode_t;

  // debounce engine state
  typedef enum logic [1:0] {
    ODT_ST_IDLE,
    ODT_ST_FIRST,
    ODT_ST_RUN
  } odt_state_t;

endpackage

// *** logic/odt_orientation_detect.sv ***
/*
  Orientation detect status block: status, config, debounce count and
  fixed compensation/threshold registers, debounce engine and interrupt
  source bit. The status byte is also offered as a live port so that the
  interrupt logic can follow it without a bus read.
  Assumes the serial register engine, the tilt-angle computation and the
  power-mode logic all run on sys_clk_in and drive the inputs directly.
  Assumes the register engine raises each read or write strobe for one
  cycle per byte, with offset and write data valid in that same cycle.
  Assumes the tilt computation flags samples above the axis limit itself;
  this block only freezes on that flag.
*/
// What this block does
// - change flag sets on first detection after activation and on any field change
// - a status register read clears the change flag unless a new change lands in the same cycle
// - reading the status register drops the pending orientation interrupt
// - lockout bit 6 set when tilt lockout angle exceeded, else zero
// - bits 2:1 report portrait up, portrait down, landscape right, landscape left
// - bit 0 reports facing: 0 front, 1 back
// - power-up: back/front 0, orientation code 00, lockout 0
// - orientation held while any axis exceeds 1.25 g
// - fields keep updating while change flag is pending
// - debounce mode 0 decrements counter when condition stops being valid
// - debounce mode 1, the default, clears counter when condition stops
// - detection runs only when enable bit 6 is set, default off
// - 8-bit read/write debounce count register, default zero
// - debounce counter resets on every wake/sleep transition
// - debounce time step depends on sample rate and oversampling mode
// - minimum latency equals debounce count times the step period
// - fixed 30 degree lockout and 75 degree back/front angles
// - compensation register read-only, reads 0100 0100
// - trip threshold register read-only, reads 1000 0100
// - interrupt source bit follows flag and enable, cleared by status read
`timescale 1ns/1ps
`default_nettype none
`include "odt_params.svh"

module odt_orientation_detect
  import odt_pkg::*;
#(
  parameter int BASE_TICK_CYCLES = `ODT_STEP_BASE_NS / `ODT_CLK_PERIOD_NS
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic active_mode_in,
  input wire logic sleep_state_in,
  input wire logic [2:0] output_sample_rate_in,
  input wire logic [1:0] osmode_in,
  input wire logic sample_valid_in,
  input wire logic tilt_lockout_in,
  input wire logic [1:0] portrait_landscape_code_in,
  input wire logic back_front_bit_in,
  input wire logic over_limit_in,
  input wire logic orient_irq_enable_in,
  output logic orientation_irq_source_out,
  output logic [7:0] orientation_status_out
);

  // register offset match, shared by the strobe decodes
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // step multiplier in 1.25 ms units for a rate and oversampling mode
  // high resolution keeps a 2.5 ms step at every rate below 400 Hz
  // unknown codes fall back to the slowest legal step of their column
  function automatic logic [7:0] step_mult(input odt_odr_t output_sample_rate, input odt_osmode_t os);
    logic [7:0] m;
    m = `ODT_MULT_16;
    case (output_sample_rate)
      ODT_ODR_800: m = `ODT_MULT_1;
      ODT_ODR_400: m = `ODT_MULT_2;
      ODT_ODR_200: m = (os == ODT_OS_HIGHRES) ? `ODT_MULT_2 : `ODT_MULT_4;
      ODT_ODR_100: m = (os == ODT_OS_HIGHRES) ? `ODT_MULT_2 : `ODT_MULT_8;
      ODT_ODR_50: m = (os == ODT_OS_HIGHRES) ? `ODT_MULT_2 : `ODT_MULT_16;
      ODT_ODR_12P5: begin
        case (os)
          ODT_OS_NORMAL: m = `ODT_MULT_16;
          ODT_OS_HIGHRES: m = `ODT_MULT_2;
          default: m = `ODT_MULT_64;
        endcase
      end
      default: begin
        case (os)
          ODT_OS_NORMAL: m = `ODT_MULT_16;
          ODT_OS_LPLN: m = `ODT_MULT_64;
          ODT_OS_HIGHRES: m = `ODT_MULT_2;
          default: m = `ODT_MULT_128;
        endcase
      end
    endcase
    return m;
  endfunction

  // base tick counter: wraps once per 1.25 ms of system clock
  // the width leaves room for the full count so the compare never truncates
  localparam int TICK_W = $clog2(BASE_TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BASE_TICK_CYCLES - 1);

  // configuration and status state
  logic debounce_mode;
  logic orientation_detect_enable;
  logic [7:0] debounce_count_value;
  logic orientation_change_flag;
  logic tilt_lockout;
  odt_pl_code_t portrait_landscape_code;
  logic back_front_bit;

  // debounce engine state
  odt_state_t state;
  logic [TICK_W-1:0] base_cnt;
  logic [7:0] mult_cnt;
  logic step_tick;
  logic [7:0] db_cnt;
  logic sleep_q;
  logic cand_lock;
  logic [1:0] cand_pl;
  logic cand_bf;
  logic cand_seen;

  // decoded bus strobes and engine terms
  logic status_read;
  logic cfg_write;
  logic cnt_write;
  logic power_edge;
  logic differs;
  logic accept;
  logic first_take;
  logic [7:0] next_db_cnt;

  // divider and flag terms
  logic base_wrap;
  logic step_due;
  logic flag_set;

  // one-cycle strobes from the register engine; any wake/sleep change
  assign status_read = reg_rd_in && addr_is(reg_addr_in, `ODT_ADDR_STATUS);
  assign cfg_write = reg_wr_in && addr_is(reg_addr_in, `ODT_ADDR_CONFIG);
  assign cnt_write = reg_wr_in && addr_is(reg_addr_in, `ODT_ADDR_DBCOUNT);
  assign power_edge = (sleep_state_in != sleep_q);

  // divider terms: end of one base period, end of a whole debounce step
  assign base_wrap = (base_cnt == TICK_LAST);
  assign step_due = (mult_cnt + 8'h01) >= step_mult(odt_odr_t'(output_sample_rate_in),
                                                   odt_osmode_t'(osmode_in));

  // configuration register, reserved bits dropped on write
  // takes effect on the edge after the strobe; bits 5:0 have no storage
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      debounce_mode <= `ODT_RST_DBMODE;
      orientation_detect_enable <= `ODT_RST_EN;
    end else if (cfg_write) begin
      debounce_mode <= reg_wdata_in[`ODT_CFG_DBMODE_BIT];
      orientation_detect_enable <= reg_wdata_in[`ODT_CFG_EN_BIT];
    end
  end

  // debounce count register
  // compared live by the engine, so a new count applies from the next step
  // a count of zero accepts a change on the first step that sees it
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      debounce_count_value <= `ODT_RST_DBCOUNT;
    end else if (cnt_write) begin
      debounce_count_value <= reg_wdata_in;
    end
  end

  // time step divider: base 1.25 ms tick times the rate/mode multiplier
  // held at zero in standby or while disabled, so the first step after
  // activation always lands one whole step later
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !orientation_detect_enable || !active_mode_in) begin
      base_cnt <= '0;
      mult_cnt <= 8'h00;
      step_tick <= 1'b0;
    end else begin
      step_tick <= 1'b0;
      if (base_wrap) begin
        base_cnt <= '0;
        if (step_due) begin
          mult_cnt <= 8'h00;
          step_tick <= 1'b1;
        end else begin
          mult_cnt <= mult_cnt + 8'h01;
        end
      end else begin
        base_cnt <= base_cnt + TICK_W'(1);
      end
    end
  end

  // latest candidate orientation from the tilt computation
  // samples above the axis limit are dropped, so the held orientation stays
  // cleared seen-flag in standby forces a fresh sample before a first detection
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cand_lock <= `ODT_RST_LOCK;
      cand_pl <= `ODT_RST_PL_CODE;
      cand_bf <= `ODT_RST_BF;
      cand_seen <= 1'b0;
    end else if (!active_mode_in || !orientation_detect_enable) begin
      cand_seen <= 1'b0;
    end else if (sample_valid_in && !over_limit_in) begin
      cand_lock <= tilt_lockout_in;
      cand_pl <= portrait_landscape_code_in;
      cand_bf <= back_front_bit_in;
      cand_seen <= 1'b1;
    end
  end

  // candidate against the reported fields; a change needs a step tick and
  // a full debounce count, the first detection a step tick and a seen candidate
  assign differs = (cand_lock != tilt_lockout)
                || (cand_pl != portrait_landscape_code)
                || (cand_bf != back_front_bit);
  assign first_take = (state == ODT_ST_FIRST) && step_tick && cand_seen && !over_limit_in;
  assign accept = (state == ODT_ST_RUN) && step_tick && differs && !over_limit_in
               && (db_cnt >= debounce_count_value);
  assign flag_set = first_take || accept;

  // debounce counter next value
  // saturates at the top so a long disagreement never wraps back to zero
  // an acceptance restarts the count for the next change
  always_comb begin
    next_db_cnt = db_cnt;
    if (power_edge || accept || state != ODT_ST_RUN) begin
      next_db_cnt = 8'h00;
    end else if (step_tick && !over_limit_in) begin
      if (differs) begin
        if (db_cnt != 8'hff) begin
          next_db_cnt = db_cnt + 8'h01;
        end
      end else if (debounce_mode) begin
        next_db_cnt = 8'h00;
      end else if (db_cnt != 8'h00) begin
        next_db_cnt = db_cnt - 8'h01;
      end
    end
  end

  // debounce counter and power-mode history
  // the sleep history feeds the wake/sleep edge detector
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      db_cnt <= 8'h00;
      sleep_q <= 1'b0;
    end else begin
      db_cnt <= next_db_cnt;
      sleep_q <= sleep_state_in;
    end
  end

  // engine state: idle in standby or disabled, first detection, running
  // leaving active mode or clearing the enable restarts with a first detection
  // so the flag always reports the first orientation seen after activation
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      state <= ODT_ST_IDLE;
    end else begin
      case (state)
        ODT_ST_IDLE: begin
          if (active_mode_in && orientation_detect_enable) begin
            state <= ODT_ST_FIRST;
          end
        end
        ODT_ST_FIRST: begin
          if (!active_mode_in || !orientation_detect_enable) begin
            state <= ODT_ST_IDLE;
          end else if (first_take) begin
            state <= ODT_ST_RUN;
          end
        end
        ODT_ST_RUN: begin
          if (!active_mode_in || !orientation_detect_enable) begin
            state <= ODT_ST_IDLE;
          end
        end
        default: state <= ODT_ST_IDLE;
      endcase
    end
  end

  // orientation fields, updated regardless of a pending flag
  // written only by a first detection or an accepted change
  // an over-limit sample can never reach them, it never becomes a candidate
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tilt_lockout <= `ODT_RST_LOCK;
      portrait_landscape_code <= odt_pl_code_t'(`ODT_RST_PL_CODE);
      back_front_bit <= `ODT_RST_BF;
    end else if (first_take || accept) begin
      tilt_lockout <= cand_lock;
      portrait_landscape_code <= odt_pl_code_t'(cand_pl);
      back_front_bit <= cand_bf;
    end
  end

  // change flag: a new event in the read cycle wins over the clear
  // so that a change landing on the read edge is never lost; the host
  // then sees the flag again on its next read
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      orientation_change_flag <= 1'b0;
    end else if (flag_set) begin
      orientation_change_flag <= 1'b1;
    end else if (status_read) begin
      orientation_change_flag <= 1'b0;
    end
  end

  // interrupt source bit toward the interrupt controller
  // level output; it drops with the flag when the status register is read
  // and rises again if the enable returns while the flag is still pending
  assign orientation_irq_source_out = orientation_change_flag && orient_irq_enable_in;

  // status byte, reserved bits zero
  // also the byte returned by a status read
  assign orientation_status_out = {orientation_change_flag, tilt_lockout, 3'h0,
                                   portrait_landscape_code, back_front_bit};

  // registered read data; unmapped offsets read zero
  // sampled at the strobe edge, so a status read returns the flag before it clears
  // the data holds until the next read strobe
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `ODT_ADDR_STATUS: reg_rdata_out <= orientation_status_out;
        `ODT_ADDR_CONFIG: reg_rdata_out <= {debounce_mode, orientation_detect_enable, 6'h00};
        `ODT_ADDR_DBCOUNT: reg_rdata_out <= debounce_count_value;
        `ODT_ADDR_BFZCOMP: reg_rdata_out <= `ODT_BFZCOMP_VALUE;
        `ODT_ADDR_TRIP: reg_rdata_out <= `ODT_TRIP_VALUE;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** verif/odt_host.sv ***
/*
  Host-side model of the serial register engine: single byte accesses.
  Assumes the bench calls xfer and that requests are taken on a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module odt_host (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  // idle bus at time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // one byte held across one rising edge; released address and data show the inverted value, strobes drop to zero
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

`default_nettype wire

// *** verif/odt_chk_asserts.sv ***
/*
  Port checker of the orientation detect block.
  Assumes it is bound to odt_orientation_detect, one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odt_params.svh"

module odt_chk
  import odt_pkg::*;
#(
  parameter int BASE_TICK_CYCLES = 25000
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic over_limit_in,
  input wire logic orient_irq_enable_in,
  input wire logic orientation_irq_source_out,
  input wire logic [7:0] orientation_status_out
);
  // all checks on the system clock, quiet in reset
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  // status read strobe
  logic st_rd;
  assign st_rd = reg_rd_in && (reg_addr_in == `ODT_ADDR_STATUS);

  irq_follow_a:
    assert property (orientation_irq_source_out ==
      (orientation_status_out[7] && orient_irq_enable_in)) else $error("irq source wrong");
  rsvd_zero_a:
    assert property (orientation_status_out[5:3] == 3'h0) else $error("reserved bits set");
  read_clear_a:
    assert property (st_rd |=> !orientation_status_out[7] ||
      $changed(orientation_status_out[6:0])) else $error("flag not cleared");
  irq_drop_a:
    assert property (st_rd |=> !orientation_irq_source_out ||
      $changed(orientation_status_out[6:0])) else $error("irq not dropped");
  status_read_a:
    assert property (st_rd |=> reg_rdata_out == $past(orientation_status_out))
      else $error("status read wrong");
  comp_fixed_a:
    assert property (reg_rd_in && reg_addr_in == `ODT_ADDR_BFZCOMP |=> reg_rdata_out == 8'h44)
      else $error("compensation wrong");
  trip_fixed_a:
    assert property (reg_rd_in && reg_addr_in == `ODT_ADDR_TRIP |=> reg_rdata_out == 8'h84)
      else $error("threshold wrong");
  unmapped_zero_a:
    assert property (reg_rd_in && !(reg_addr_in inside {[8'h10:8'h14]}) |=>
      reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  limit_hold_a:
    assert property (over_limit_in && $past(over_limit_in) |->
      $stable(orientation_status_out[6:0])) else $error("fields moved over limit");
  reset_clear_a:
    assert property ($fell(srst_in) |-> orientation_status_out == 8'h00)
      else $error("status not clear after reset");

  // main scenarios reached
  cover property ($rose(orientation_status_out[7]));
  cover property (orientation_irq_source_out);
  cover property (over_limit_in ##1 over_limit_in);
endmodule

bind odt_orientation_detect odt_chk #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) u_odt_chk (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .over_limit_in(over_limit_in),
  .orient_irq_enable_in(orient_irq_enable_in),
  .orientation_irq_source_out(orientation_irq_source_out),
  .orientation_status_out(orientation_status_out));

`default_nettype wire

// *** verif/tb_top.sv ***
/*
  Self-checking bench of the orientation detect block.
  Assumes a divider of 4 clocks, so one debounce step is 4 clocks at 800 Hz.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import odt_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr, reg_wdata, rdata, status;
  logic reg_wr, reg_rd, irq, rd_d = 1'b0;
  logic active = 1'b0, sleep = 1'b0, valid = 1'b0, over = 1'b0, irq_en = 1'b0;
  logic lock = 1'b0, bf = 1'b0;
  logic [1:0] code = 2'h0, osm = 2'h0;
  logic [2:0] rate = 3'h0;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int comparisons = 0;

  // clock and candidate strobe every other cycle
  always #25 sys_clk_in = ~sys_clk_in;
  always @(negedge sys_clk_in) valid <= ~valid;

  odt_host u_odt_host (.clk_in(sys_clk_in), .addr_out(reg_addr), .wr_out(reg_wr),
    .rd_out(reg_rd), .wdata_out(reg_wdata));
  odt_orientation_detect #(.BASE_TICK_CYCLES(4)) u_odt_orientation_detect (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(rdata), .active_mode_in(active), .sleep_state_in(sleep),
    .output_sample_rate_in(rate), .osmode_in(osm), .sample_valid_in(valid),
    .tilt_lockout_in(lock), .portrait_landscape_code_in(code), .back_front_bit_in(bf),
    .over_limit_in(over), .orient_irq_enable_in(irq_en),
    .orientation_irq_source_out(irq), .orientation_status_out(status));

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp1(input string n, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask

  // read data appears one cycle after the strobe; match it with the oldest note
  always @(posedge sys_clk_in) rd_d <= reg_rd;
  always @(negedge sys_clk_in) begin
    if (rd_d) cmp8("rdata", exp_q.pop_front(), rdata);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_odt_host.xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_odt_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  function automatic logic [7:0] st(input logic p, input logic [1:0] c);
    return {p, lock, 3'h0, c, bf};
  endfunction
  // 14 steps away, 2 steps back, 14 steps away again
  task automatic wiggle;
    code = code + 2'h1;
    cyc(56);
    code = code - 2'h1;
    cyc(8);
    code = code + 2'h1;
    cyc(56);
  endtask

  task automatic results;
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h7655120c));
    osm = 2'($urandom());
    repeat (4) @(negedge sys_clk_in);
    srst_in = 1'b0;
    rc(8'h10, 8'h00);
    rc(8'h11, 8'h80);
    rc(8'h12, 8'h00);
    rc(8'h20, 8'h00);
    wr(8'h13, 8'hff);
    wr(8'h14, 8'h00);
    wr(8'h10, 8'hff);
    rc(8'h13, 8'h44);
    rc(8'h14, 8'h84);
    rc(8'h10, 8'h00);
    wr(8'h11, 8'hff);
    rc(8'h11, 8'hc0);
    wr(8'h12, 8'ha5);
    rc(8'h12, 8'ha5);
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h80);
    active = 1'b1;
    code = 2'h2;
    cyc(40);
    rc(8'h10, 8'h00);
    active = 1'b0;
    code = 2'h0;
    wr(8'h11, 8'hc0);
    active = 1'b1;
    cyc(40);
    cmp1("irq", 1'b0, irq);
    irq_en = 1'b1;
    cyc(1);
    cmp1("irq", 1'b1, irq);
    rc(8'h10, 8'h80);
    cmp1("irq", 1'b0, irq);
    for (int i = 0; i < 4; i++) begin
      {lock, bf} = 2'($urandom());
      code = i[1:0];
      cyc(40);
      if (i[0]) rc(8'h10, st(1'b1, code));
    end
    over = 1'b1;
    cyc(2);
    code = code + 2'h1;
    cyc(40);
    rc(8'h10, st(1'b0, code - 2'h1));
    over = 1'b0;
    cyc(40);
    rc(8'h10, st(1'b1, code));
    wr(8'h12, 8'h14);
    wiggle();
    rc(8'h10, st(1'b0, code - 2'h1));
    cyc(40);
    rc(8'h10, st(1'b1, code));
    wr(8'h11, 8'h40);
    wiggle();
    rc(8'h10, st(1'b1, code));
    code = code + 2'h1;
    cyc(56);
    sleep = 1'b1;
    cyc(56);
    rc(8'h10, st(1'b0, code - 2'h1));
    // first step after re-enable at 200 Hz: 2.5 ms in high resolution, else 5 ms
    wr(8'h11, 8'h80);
    rate = 3'h2;
    wr(8'h11, 8'hc0);
    cyc((osm == 2'h2) ? 8 : 16);
    cmp1("flag", 1'b0, status[7]);
    cyc(1);
    cmp1("flag", 1'b1, status[7]);
    rc(8'h10, st(1'b1, code));
    results();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    mismatches++;
    results();
  end
endmodule

`default_nettype wire
